// File: logic/icm_pkg.sv
// Purpose: shared constants and types for the master event / slave mask block
// Assumes: 125 MHz clock, standard-mode bus timing
// Notes: ctrl bits [4:0] hold the event/mask bits at positions 5..1
`default_nettype none

package icm_pkg;

    // clock and bus timing
    localparam int CLK_NS = 8;
    localparam int QTR_NS = 2500;
    localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 9;
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(QTR_CYC - 1);
    localparam logic [TMR_W-1:0] TMR_ZERO = 9'h000;

    // positions inside the 5-bit control field
    localparam int B_ACK_LVL = 4;
    localparam int B_ACK_GO = 3;
    localparam int B_RX_GO = 2;
    localparam int B_STOP_GO = 1;
    localparam int B_RST_GO = 0;

    // reset values
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [7:0] RX_RST = 8'h00;
    localparam logic [1:0] DRV_RST = 2'h0;

    // phase and bit counts
    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_SCL_UP = 2'h1;
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [1:0] PH_STOP_LAST = 2'h2;
    localparam logic [1:0] PH_LAST = 2'h3;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RSTART,
        ST_STOP,
        ST_ACK,
        ST_RX
    } icm_state_t;

endpackage

`default_nettype wire

// File: logic/icm_pin_if.sv
// Purpose: carries raw and synchronised bus pin levels between modules
// Assumes: one clock domain on the synchronised side
// Notes: raw levels come straight from the pins
`default_nettype none

interface icm_pin_if;
    logic scl_raw;
    logic sda_raw;
    logic scl_s;
    logic sda_s;
    modport sync (input scl_raw, input sda_raw, output scl_s, output sda_s);
    modport core (output scl_raw, output sda_raw, input scl_s, input sda_s);
endinterface

`default_nettype wire

// File: logic/icm_pin_sync.sv
// Purpose: two-flop synchronisers for the clock and data pins
// Assumes: pins are asynchronous to clk
// Notes: first stage feeds only the second stage
`default_nettype none

module icm_pin_sync
    import icm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    icm_pin_if.sync pins
);

    logic [1:0] scl_q_r;
    logic [1:0] sda_q_r;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scl_q_r <= 2'h3;
            sda_q_r <= 2'h3;
        end
        else if (ce)
        begin
            scl_q_r <= {scl_q_r[0], pins.scl_raw};
            sda_q_r <= {sda_q_r[0], pins.sda_raw};
        end
    end

    assign pins.scl_s = scl_q_r[1];
    assign pins.sda_s = sda_q_r[1];

endmodule // icm_pin_sync

`default_nettype wire

// File: logic/icm_master_event_ctrl.sv
// Purpose: master bus events and slave address masking on shared bits
// Assumes: open-drain pins, pulled high outside; 125 MHz clock
// Notes: ctrl bits [4:0] stand at positions 5..1 of the control register
`default_nettype none

module icm_master_event_ctrl
    import icm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic master_mode,
    input wire logic wr_en,
    input wire logic [4:0] wr_data,
    output logic [4:0] ctrl_rd,
    output logic addr_mask_b5,
    output logic addr_mask_b4,
    output logic addr_mask_b3,
    output logic addr_mask_b2,
    output logic addr_mask_b1,
    output logic busy,
    output logic [7:0] rx_data,
    output logic rx_done,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);

    icm_pin_if pins ();

    icm_state_t state_r, state_nxt, launch_st;
    logic [1:0] phase_r, phase_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic [4:0] ctrl_r, ctrl_nxt;
    logic [4:0] mask_r, mask_nxt;
    logic [1:0] drv_r, drv_nxt;
    logic [7:0] shift_r, rx_data_r;
    logic rx_done_r;
    wire go_rst, go_stop, go_ack, go_rx;
    wire in_idle, launch, tmr_zero, step;
    wire last_ph, seq_end, sample;
    wire [4:0] clr_mask;

    // returns {scl_low, sda_low} for a state and phase
    function automatic logic [1:0] drv(
        input icm_state_t st,
        input logic [1:0] ph,
        input logic lvl,
        input logic [1:0] hold
    );
        logic [1:0] d;
        d = hold;
        case (st)
            ST_RSTART: d = (ph == PH_FIRST) ? 2'h2 :
                           (ph == PH_SCL_UP) ? 2'h0 :
                           (ph == PH_SAMPLE) ? 2'h1 : 2'h3;
            ST_STOP: d = (ph == PH_FIRST) ? 2'h3 :
                         (ph == PH_SCL_UP) ? 2'h1 : 2'h0;
            ST_ACK: d = {(ph == PH_FIRST) || (ph == PH_LAST), !lvl};
            ST_RX: d = {(ph == PH_FIRST) || (ph == PH_LAST), 1'b0};
            ST_IDLE: d = hold;
            default: d = hold;
        endcase
        return d;
    endfunction

    // which go bit a finished sequence clears
    function automatic logic [4:0] done_bit(input icm_state_t st);
        logic [4:0] m;
        m = 5'h00;
        case (st)
            ST_RSTART: m[B_RST_GO] = 1'b1;
            ST_STOP: m[B_STOP_GO] = 1'b1;
            ST_ACK: m[B_ACK_GO] = 1'b1;
            ST_RX: m[B_RX_GO] = 1'b1;
            default: m = 5'h00;
        endcase
        return m;
    endfunction

    icm_pin_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pins(pins.sync)
    );

    assign pins.scl_raw = scl_in;
    assign pins.sda_raw = sda_in;

    assign go_rst = master_mode && ctrl_r[B_RST_GO];
    assign go_stop = master_mode && ctrl_r[B_STOP_GO];
    assign go_ack = master_mode && ctrl_r[B_ACK_GO];
    assign go_rx = master_mode && ctrl_r[B_RX_GO];
    assign launch_st = go_rst ? ST_RSTART :
                       go_stop ? ST_STOP :
                       go_ack ? ST_ACK :
                       go_rx ? ST_RX : ST_IDLE;
    assign in_idle = (state_r == ST_IDLE);
    assign launch = in_idle && (launch_st != ST_IDLE);
    assign tmr_zero = (tmr_r == TMR_ZERO);
    // clock stretching: released scl must read high before moving on
    assign step = !in_idle && tmr_zero &&
                  ((phase_r != PH_SCL_UP) || pins.scl_s);
    assign last_ph = (state_r == ST_STOP) ? (phase_r == PH_STOP_LAST) :
                     (phase_r == PH_LAST);
    assign seq_end = step && last_ph &&
                     ((state_r != ST_RX) || (bit_r == BIT_LAST));
    assign sample = step && (state_r == ST_RX) && (phase_r == PH_SAMPLE);
    assign clr_mask = seq_end ? done_bit(state_r) : 5'h00;

    always_comb
    begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        bit_nxt = bit_r;
        tmr_nxt = tmr_r;
        if (launch)
        begin
            state_nxt = launch_st;
            phase_nxt = PH_FIRST;
            bit_nxt = BIT_FIRST;
            tmr_nxt = TMR_LOAD;
        end
        else if (seq_end)
            state_nxt = ST_IDLE;
        else if (step)
        begin
            phase_nxt = phase_r + 2'h1;
            tmr_nxt = TMR_LOAD;
            if (phase_r == PH_LAST)
                bit_nxt = bit_r + 3'h1;
        end
        else if (!tmr_zero)
            tmr_nxt = tmr_r - 9'h001;
    end

    // write wins over a hardware clear in the same cycle
    assign ctrl_nxt = wr_en ? wr_data : (ctrl_r & ~clr_mask);
    assign mask_nxt = master_mode ? 5'h00 : ctrl_nxt;
    assign drv_nxt = drv(state_nxt, phase_nxt, ctrl_r[B_ACK_LVL], drv_r);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            phase_r <= PH_FIRST;
            bit_r <= BIT_FIRST;
            tmr_r <= TMR_ZERO;
            ctrl_r <= CTRL_RST;
            mask_r <= CTRL_RST;
            drv_r <= DRV_RST;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            bit_r <= bit_nxt;
            tmr_r <= tmr_nxt;
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            drv_r <= drv_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shift_r <= RX_RST;
            rx_data_r <= RX_RST;
            rx_done_r <= 1'b0;
        end
        else if (ce)
        begin
            if (sample)
                shift_r <= {shift_r[6:0], pins.sda_s};
            if (seq_end && (state_r == ST_RX))
                rx_data_r <= shift_r;
            rx_done_r <= seq_end && (state_r == ST_RX);
        end
    end

    assign ctrl_rd = ctrl_r;
    assign addr_mask_b5 = mask_r[B_ACK_LVL];
    assign addr_mask_b4 = mask_r[B_ACK_GO];
    assign addr_mask_b3 = mask_r[B_RX_GO];
    assign addr_mask_b2 = mask_r[B_STOP_GO];
    assign addr_mask_b1 = mask_r[B_RST_GO];
    assign busy = !in_idle;
    assign rx_data = rx_data_r;
    assign rx_done = rx_done_r;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = drv_r[1];
    assign sda_oe = drv_r[0];

    default clocking cb_chk @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_ack_launch;
        (ce && in_idle && go_ack && !go_rst && !go_stop) |=>
            (state_r == ST_ACK);
    endproperty
    a_ack_launch: assert property (p_ack_launch)
        else $error("ack sequence did not start");
    property p_ack_clear;
        (ce && seq_end && state_r == ST_ACK && !wr_en) |=>
            (!ctrl_r[B_ACK_GO] && scl_oe && !busy);
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("ack go bit not cleared at end");
    property p_rx_launch;
        (ce && in_idle && go_rx && !go_ack && !go_rst && !go_stop) |=>
            (state_r == ST_RX && bit_r == BIT_FIRST);
    endproperty
    a_rx_launch: assert property (p_rx_launch)
        else $error("byte reception did not start");
    property p_rx_end;
        (ce && seq_end && state_r == ST_RX && !wr_en) |=>
            (!ctrl_r[B_RX_GO] && rx_done && rx_data == $past(shift_r));
    endproperty
    a_rx_end: assert property (p_rx_end)
        else $error("reception end not reported");
    property p_stop_end;
        (ce && seq_end && state_r == ST_STOP && !wr_en) |=>
            (!ctrl_r[B_STOP_GO] && !scl_oe && !sda_oe);
    endproperty
    a_stop_end: assert property (p_stop_end)
        else $error("stop did not release lines");
    property p_rst_end;
        (ce && seq_end && state_r == ST_RSTART && !wr_en) |=>
            (!ctrl_r[B_RST_GO] && scl_oe && sda_oe);
    endproperty
    a_rst_end: assert property (p_rst_end)
        else $error("repeated start end state wrong");
    property p_ack_level;
        ($past(ce) && state_r == ST_ACK && phase_r == PH_SAMPLE) |->
            (sda_oe == !$past(ctrl_r[B_ACK_LVL]));
    endproperty
    a_ack_level: assert property (p_ack_level)
        else $error("ack level not driven");
    property p_mask_wr;
        (ce && wr_en && !master_mode) |=> ({addr_mask_b5, addr_mask_b4,
            addr_mask_b3, addr_mask_b2, addr_mask_b1} == $past(wr_data));
    endproperty
    a_mask_wr: assert property (p_mask_wr)
        else $error("slave mask does not follow write");
    property p_mask_keep;
        (ce && !wr_en && !master_mode) ##1 (ce && !wr_en && !master_mode)
            |-> $stable(ctrl_r) && !busy;
    endproperty
    a_mask_keep: assert property (p_mask_keep)
        else $error("slave mask bits changed by hardware");
    // masks read zero in master mode
    property p_mask_master;
        (ce && master_mode) |=> !(addr_mask_b5 || addr_mask_b4 ||
            addr_mask_b3 || addr_mask_b2 || addr_mask_b1);
    endproperty
    a_mask_master: assert property (p_mask_master)
        else $error("mask active in master mode");

endmodule // icm_master_event_ctrl

`default_nettype wire

// File: verification/icm_bus_dev.sv
// Purpose: far-side bus device that sends one byte and may stretch clock
// Assumes: both lines pulled high, device only pulls low
// Notes: arm restarts the byte at its first bit
`default_nettype none

module icm_bus_dev (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic arm,
    input wire logic stretch,
    input wire logic [7:0] tx_byte,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] idx_r;
    logic [8:0] hold_r;
    logic scl_q;
    logic oe_q;
    logic hold_low;
    logic bit_low;
    // hold scl from the very cycle it is released, no high glitch
    assign hold_low = hold_r != 9'h000 || (stretch && oe_q && !scl_oe);
    assign bit_low = idx_r < 4'h8 && !tx_byte[3'h7 - idx_r[2:0]];
    // wired-and with pull-ups
    assign scl = !(scl_oe | hold_low);
    assign sda = !(sda_oe | bit_low);
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            idx_r <= 4'h8;
            hold_r <= 9'h000;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
        end
        else
        begin
            scl_q <= scl;
            oe_q <= scl_oe;
            if (arm)
                idx_r <= 4'h0;
            else if (scl_q && !scl && idx_r < 4'h8)
                idx_r <= idx_r + 4'h1;
            if (stretch && oe_q && !scl_oe)
                hold_r <= 9'h190;
            else if (hold_low)
                hold_r <= hold_r - 9'h001;
        end
    end
endmodule // icm_bus_dev

`default_nettype wire

// File: verification/testbench.sv
// Purpose: self-checking bench for master events and slave masks
// Assumes: ce held high, bus modelled by icm_bus_dev
// Notes: event results queued by the driver, checked by a watcher; mask results checked inline
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import icm_pkg::*;
    logic clk, nrst, master_mode, wr_en, arm, stretch, busy_q;
    logic [4:0] wr_data, ctrl_rd;
    logic [7:0] rx_data, tx_byte, rnd;
    logic b5, b4, b3, b2, b1, busy, rx_done;
    logic scl, sda, scl_oe, sda_oe;
    logic [1:0] pin_out;
    logic [6:0] endq[$];
    logic [7:0] rxq[$];
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;

    icm_master_event_ctrl icm_master_event_ctrl_i (
        .clk(clk), .nrst(nrst), .ce(1'b1), .master_mode(master_mode),
        .wr_en(wr_en), .wr_data(wr_data), .ctrl_rd(ctrl_rd),
        .addr_mask_b5(b5), .addr_mask_b4(b4), .addr_mask_b3(b3),
        .addr_mask_b2(b2), .addr_mask_b1(b1), .busy(busy),
        .rx_data(rx_data), .rx_done(rx_done), .scl_in(scl),
        .scl_out(pin_out[1]), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(pin_out[0]), .sda_oe(sda_oe));
    icm_bus_dev icm_bus_dev_i (
        .clk(clk), .nrst(nrst), .scl_oe(scl_oe), .sda_oe(sda_oe),
        .arm(arm), .stretch(stretch), .tx_byte(tx_byte),
        .scl(scl), .sda(sda));

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [4:0] v);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_data <= v;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic mask_chk(input logic [4:0] v);
        wr(v);
        repeat (20) @(posedge clk);
        cmp("masks", {3'h0, v}, {3'h0, b5, b4, b3, b2, b1});
        cmp("slave ctrl_rd", {3'h0, v}, {3'h0, ctrl_rd});
        cmp("slave busy", 8'h00, {7'h00, busy});
        $display("test mask %h done", v);
    endtask

    task automatic go(input logic [4:0] v, input logic [6:0] e);
        int n;
        endq.push_back(e);
        wr(v);
        n = 0;
        while (busy !== 1'b1 && n < 10)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (busy !== 1'b0 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        if (busy !== 1'b0)
            failures++;
        repeat (2) @(posedge clk);
        $display("test event %h done", v);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            failures++;
            give_verdict();
        end
    end

    always @(posedge clk)
    begin
        busy_q <= busy;
        if (rx_done)
            cmp("rx_data", rxq.size() ? rxq.pop_front() : 8'hXX, rx_data);
        if (busy_q === 1'b1 && busy === 1'b0)
            cmp("ctrl_oe", endq.size() ? {1'b0, endq.pop_front()} : 8'hXX,
                {1'b0, ctrl_rd, scl_oe, sda_oe});
    end

    initial
    begin
        nrst = 1'b0;
        master_mode = 1'b0;
        wr_en = 1'b0;
        wr_data = 5'h00;
        arm = 1'b0;
        stretch = 1'b0;
        tx_byte = 8'h00;
        rnd = 8'h56;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        cmp("reset ctrl_rd", 8'h00, {3'h0, ctrl_rd});
        mask_chk(5'h1F);
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            mask_chk(rnd[4:0]);
        end
        mask_chk(5'h00);
        master_mode <= 1'b1;
        go(5'h01, {5'h00, 2'b11});
        rnd = lfsr(rnd);
        tx_byte <= rnd;
        stretch <= 1'b1;
        arm <= 1'b1;
        rxq.push_back(rnd);
        @(posedge clk);
        arm <= 1'b0;
        go(5'h04, {5'h00, 2'b10});
        stretch <= 1'b0;
        go(5'h18, {5'h10, 2'b10});
        go(5'h08, {5'h00, 2'b11});
        go(5'h02, {5'h00, 2'b00});
        cmp("queues", 8'h00, 8'(endq.size() + rxq.size()));
        cmp("pin out", 8'h00, {6'h00, pin_out});
        give_verdict();
    end
endmodule // testbench

`default_nettype wire
